//--- logic/cbag_bus_ctrl.v
// Purpose: Bus strobe, stall, reset sequence and address generation of the core
// Assumes: Core sequencer issues one request at a time; reset, ready and set-overflow pins pass two flip-flops
// Notes: Address, data and strobe output enables follow the bus enable pin without a clock, by design; the ready enable is registered
`timescale 1ns/1ps
`include "cbag_consts.vh"
`default_nettype none
module cbag_bus_ctrl (
  input wire ref_clk,
  input wire rst,
  input wire reset_in_n,
  input wire ready_in,
  input wire set_overflow_in_n,
  input wire bus_drive_enable,
  input wire [7:0] data_in,
  input wire req_valid,
  input wire [3:0] req_op,
  input wire req_write,
  input wire [7:0] req_wdata,
  input wire req_use_x,
  input wire req_cond_met,
  input wire [1:0] req_vec_sel,
  input wire [7:0] index_x,
  input wire [7:0] index_y,
  input wire [7:0] stack_ptr,
  input wire wait_for_interrupt_instr,
  input wire wake,
  input wire status_wr,
  input wire [7:0] status_wdata,
  output reg [15:0] addr_out,
  output wire addr_oe,
  output reg [7:0] data_out,
  output wire data_oe,
  output reg read_write_strobe,
  output wire rw_oe,
  output reg ready_out,
  output reg ready_oe,
  output reg wait_n,
  output reg opcode_fetch,
  output reg vector_pull_n,
  output reg busy,
  output reg req_taken,
  output reg done,
  output reg [7:0] rdata,
  output reg [15:0] pc_out,
  output reg [7:0] status_out,
  output reg reset_active
);
  localparam ST_HOLD = 3'h0;
  localparam ST_RSEQ = 3'h1;
  localparam ST_IDLE = 3'h2;
  localparam ST_ACC = 3'h3;
  localparam ST_SECOND = 3'h4;

  wire rst_pin_s;
  wire rdy_s;
  wire so_s;
  reg [2:0] state;
  reg [2:0] cnt;
  reg [7:0] op_lo;
  reg [7:0] op_hi;
  reg [7:0] tmp_lo;
  reg [3:0] cur_op;
  reg cur_cond;
  reg so_d;
  reg [15:0] req_addr;
  reg req_is_data;
  reg [15:0] sext_off;

  cbag_sync #(.RESET_VAL(1'b0)) u_sync_rst (
    .ref_clk(ref_clk),
    .rst(rst),
    .din(reset_in_n),
    .dout(rst_pin_s)
  );

  cbag_sync #(.RESET_VAL(1'b1)) u_sync_rdy (
    .ref_clk(ref_clk),
    .rst(rst),
    .din(ready_in),
    .dout(rdy_s)
  );

  cbag_sync #(.RESET_VAL(1'b1)) u_sync_so (
    .ref_clk(ref_clk),
    .rst(rst),
    .din(set_overflow_in_n),
    .dout(so_s)
  );

  // Bus enable is asynchronous, so the pin gates the drivers directly
  assign addr_oe = bus_drive_enable; // RULE4
  assign data_oe = bus_drive_enable & ~read_write_strobe; // RULE4
  assign rw_oe = bus_drive_enable; // RULE3

  always @* begin
    sext_off = {{8{op_lo[7]}}, op_lo}; // RULE23
    req_is_data = 1'b0;
    case (req_op)
      `CBAG_OP_ABS: begin
        req_addr = {op_hi, op_lo}; // RULE18
        req_is_data = 1'b1;
      end
      `CBAG_OP_ABS_X: begin
        req_addr = {op_hi, op_lo} + {8'h00, index_x}; // RULE20
        req_is_data = 1'b1;
      end
      `CBAG_OP_ABS_Y: begin
        req_addr = {op_hi, op_lo} + {8'h00, index_y}; // RULE20
        req_is_data = 1'b1;
      end
      `CBAG_OP_ZP: begin
        req_addr = {`CBAG_ZERO_PAGE, op_lo}; // RULE25
        req_is_data = 1'b1;
      end
      `CBAG_OP_STACK: begin
        req_addr = {`CBAG_STACK_PAGE, stack_ptr}; // RULE24
        req_is_data = 1'b1;
      end
      `CBAG_OP_JUMP_IND: begin
        req_addr = {op_hi, op_lo} + (req_use_x ? {8'h00, index_x} : 16'h0000); // RULE19
      end
      `CBAG_OP_VECTOR: begin
        case (req_vec_sel)
          `CBAG_VSEL_NMI: req_addr = `CBAG_VEC_NMI; // RULE17
          `CBAG_VSEL_RESET: req_addr = `CBAG_VEC_RESET; // RULE17
          default: req_addr = `CBAG_VEC_BREAK_IRQ; // RULE17
        endcase
      end
      default: begin
        req_addr = pc_out;
      end
    endcase
  end

  // Status register: set-overflow edge beats a software write
  always @(posedge ref_clk) begin
    if (rst) begin
      status_out <= `CBAG_STATUS_RESET;
      so_d <= 1'b1;
    end else begin
      so_d <= so_s;
      if (status_wr) begin
        status_out <= status_wdata;
      end
      if (!rst_pin_s) begin
        status_out[`CBAG_BIT_IRQ_DIS] <= 1'b1; // RULE9 RULE10
        status_out[`CBAG_BIT_DECIMAL] <= 1'b0; // RULE9 RULE10
      end
      if (so_d && !so_s) begin
        status_out[`CBAG_BIT_OVERFLOW] <= 1'b1; // RULE13
      end
    end
  end

  // Wait handshake; a new wait beats a simultaneous wake
  always @(posedge ref_clk) begin
    if (rst) begin
      ready_out <= 1'b0;
      ready_oe <= 1'b0;
      wait_n <= 1'b1;
    end else begin
      ready_out <= 1'b0;
      if (wait_for_interrupt_instr && rst_pin_s) begin
        ready_oe <= 1'b1; // RULE7
        wait_n <= 1'b0; // RULE7
      end else if (wake || !rst_pin_s) begin
        ready_oe <= 1'b0;
        wait_n <= 1'b1;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_HOLD;
      cnt <= 3'h0;
      op_lo <= 8'h00;
      op_hi <= 8'h00;
      tmp_lo <= 8'h00;
      cur_op <= `CBAG_OP_FETCH_OP;
      cur_cond <= 1'b0;
      pc_out <= 16'h0000;
      addr_out <= 16'h0000;
      data_out <= 8'h00;
      read_write_strobe <= 1'b1;
      opcode_fetch <= 1'b0;
      vector_pull_n <= 1'b1;
      busy <= 1'b1;
      req_taken <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
      reset_active <= 1'b1;
    end else begin
      done <= 1'b0;
      req_taken <= 1'b0;
      if (!rst_pin_s) begin
        // Ready has no say while the reset pin is low
        state <= ST_HOLD; // RULE8
        read_write_strobe <= 1'b1;
        opcode_fetch <= 1'b0;
        vector_pull_n <= 1'b1;
        busy <= 1'b1;
        reset_active <= 1'b1;
      end else begin
        case (state)
          ST_HOLD: begin
            // First cycle with the pin high is the rising edge
            state <= ST_RSEQ; // RULE11
            cnt <= 3'h0;
            addr_out <= {`CBAG_STACK_PAGE, stack_ptr};
            read_write_strobe <= 1'b1;
          end
          ST_RSEQ: begin
            if (rdy_s) begin // RULE5 RULE6
              cnt <= cnt + 3'h1;
              if (cnt + 3'h1 == `CBAG_RESET_VEC_LO_CYC) begin
                addr_out <= `CBAG_VEC_RESET; // RULE12
                vector_pull_n <= 1'b0; // RULE16
              end else if (cnt + 3'h1 == `CBAG_RESET_VEC_HI_CYC) begin
                addr_out <= `CBAG_VEC_RESET + 16'h0001; // RULE12
              end
              if (cnt == `CBAG_RESET_VEC_LO_CYC) begin
                tmp_lo <= data_in;
              end
              if (cnt == `CBAG_RESET_CYCLES - 3'h1) begin
                pc_out <= {data_in, tmp_lo}; // RULE12
                vector_pull_n <= 1'b1;
                state <= ST_IDLE; // RULE11
                busy <= 1'b0;
                reset_active <= 1'b0;
              end
            end
          end
          ST_IDLE: begin
            // Requests wait while ready is low: nothing moves
            if (req_valid && rdy_s) begin // RULE5
              state <= ST_ACC;
              busy <= 1'b1;
              req_taken <= 1'b1;
              cur_op <= req_op;
              cur_cond <= req_cond_met;
              addr_out <= req_addr;
              data_out <= req_wdata;
              read_write_strobe <= ~(req_write & req_is_data); // RULE2
              opcode_fetch <= (req_op == `CBAG_OP_FETCH_OP); // RULE14
              vector_pull_n <= ~(req_op == `CBAG_OP_VECTOR); // RULE16
            end
          end
          ST_ACC: begin
            // Without ready every register but req_taken keeps its value, fetch included
            if (rdy_s) begin // RULE1 RULE5 RULE6 RULE15
              rdata <= data_in;
              case (cur_op)
                `CBAG_OP_FETCH_OP: pc_out <= pc_out + 16'h0001;
                `CBAG_OP_FETCH_LO: begin
                  op_lo <= data_in; // RULE21
                  pc_out <= pc_out + 16'h0001;
                end
                `CBAG_OP_FETCH_HI: begin
                  op_hi <= data_in; // RULE18
                  pc_out <= pc_out + 16'h0001;
                end
                `CBAG_OP_BRANCH: begin
                  if (cur_cond) begin
                    pc_out <= pc_out + sext_off; // RULE22
                  end
                end
                `CBAG_OP_JUMP_ABS: pc_out <= {op_hi, op_lo};
                default: pc_out <= pc_out;
              endcase
              if (cur_op == `CBAG_OP_JUMP_IND || cur_op == `CBAG_OP_VECTOR) begin
                tmp_lo <= data_in; // RULE19
                addr_out <= addr_out + 16'h0001;
                state <= ST_SECOND;
              end else begin
                state <= ST_IDLE;
                done <= 1'b1;
                busy <= 1'b0;
                read_write_strobe <= 1'b1;
                opcode_fetch <= 1'b0;
                vector_pull_n <= 1'b1;
              end
            end
          end
          ST_SECOND: begin
            if (rdy_s) begin // RULE5 RULE6
              rdata <= data_in;
              pc_out <= {data_in, tmp_lo}; // RULE19
              state <= ST_IDLE;
              done <= 1'b1;
              busy <= 1'b0;
              vector_pull_n <= 1'b1;
            end
          end
          default: begin
            state <= ST_HOLD;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- logic/cbag_consts.vh
// Purpose: Shared constants of the bus control and address generator
// Assumes: 8-bit data, 16-bit address, one 200 MHz clock
// Notes: Included by bare name; definitions only
// Overview of operation
// RULE1: Fully static; every register holds when idle
// RULE2: Strobe high on reads, low on writes
// RULE3: Strobe floats while bus enable low
// RULE4: Bus enable gates address, data, strobe drivers
// RULE5: Ready low halts core, address held
// RULE6: Ready high again resumes on next edge
// RULE7: Wait instruction pulls ready and wait low
// RULE8: Reset held two cycles; ready ignored then
// RULE9: Reset touches only decimal and interrupt-disable bits
// RULE10: Reset sets interrupt-disable, clears decimal
// RULE11: Reset release runs exactly seven-cycle sequence
// RULE12: Sequence loads counter from FFFC, FFFD
// RULE13: Falling set-overflow input sets overflow flag
// RULE14: Opcode-fetch marker high for whole fetch cycle
// RULE15: Ready low during opcode fetch stops core
// RULE16: Vector pull low while reading vector bytes
// RULE17: Vectors FFFE break/irq, FFFC reset, FFFA nmi
// RULE18: Absolute address is low then high operand
// RULE19: Indirect jump pointer, optional index, low first
// RULE20: Absolute indexed adds index to 16-bit operand
// RULE21: Immediate is byte two; implied single byte
// RULE22: Taken branch adds offset to program counter
// RULE23: Branch offset sign-extended to sixteen bits
// RULE24: Stack page fixed at one, pointer low
// RULE25: Zero page high byte is zero
`ifndef CBAG_CONSTS_VH
`define CBAG_CONSTS_VH

`define CBAG_VEC_BREAK_IRQ 16'hFFFE
`define CBAG_VEC_RESET 16'hFFFC
`define CBAG_VEC_NMI 16'hFFFA
`define CBAG_STACK_PAGE 8'h01
`define CBAG_ZERO_PAGE 8'h00

`define CBAG_RESET_CYCLES 3'h7
`define CBAG_RESET_VEC_LO_CYC 3'h5
`define CBAG_RESET_VEC_HI_CYC 3'h6
`define CBAG_RESET_HOLD_MIN 2

`define CBAG_STATUS_RESET 8'h34
`define CBAG_BIT_DECIMAL 3
`define CBAG_BIT_IRQ_DIS 2
`define CBAG_BIT_OVERFLOW 6

`define CBAG_OP_FETCH_OP 4'h0
`define CBAG_OP_FETCH_LO 4'h1
`define CBAG_OP_FETCH_HI 4'h2
`define CBAG_OP_IMPLIED 4'h3
`define CBAG_OP_ABS 4'h4
`define CBAG_OP_ABS_X 4'h5
`define CBAG_OP_ABS_Y 4'h6
`define CBAG_OP_ZP 4'h7
`define CBAG_OP_STACK 4'h8
`define CBAG_OP_JUMP_IND 4'h9
`define CBAG_OP_BRANCH 4'hA
`define CBAG_OP_VECTOR 4'hB
`define CBAG_OP_JUMP_ABS 4'hC

`define CBAG_VSEL_BREAK_IRQ 2'h0
`define CBAG_VSEL_NMI 2'h1
`define CBAG_VSEL_RESET 2'h2

`endif

//--- logic/cbag_sync.v
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Input is asynchronous to ref_clk
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module cbag_sync #(
  parameter RESET_VAL = 1'b1
) (
  input wire ref_clk,
  input wire rst,
  input wire din,
  output reg dout
);
  reg stage1;

  always @(posedge ref_clk) begin
    if (rst) begin
      stage1 <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule
`default_nettype wire

//--- bench/cbag_chk_assertions.sv
// Purpose: Port-level checks of the bus control block
// Assumes: Ready stays high while a reset sequence runs
// Notes: Bound to the block from the bench top
`timescale 1ns/1ps
`default_nettype none
module cbag_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reset_in_n,
  input wire logic ready_in,
  input wire logic set_overflow_in_n,
  input wire logic bus_drive_enable,
  input wire logic wait_for_interrupt_instr,
  input wire logic [15:0] addr_out,
  input wire logic data_oe,
  input wire logic read_write_strobe,
  input wire logic rw_oe,
  input wire logic ready_oe,
  input wire logic wait_n,
  input wire logic opcode_fetch,
  input wire logic vector_pull_n,
  input wire logic [7:0] status_out,
  input wire logic reset_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  rw_float_a: assert property (rw_oe == bus_drive_enable)
    else $error("strobe enable wrong");
  data_drive_a: assert property (data_oe == (bus_drive_enable && !read_write_strobe))
    else $error("data enable wrong");
  // Pins pass two flops, so the stall acts two samples late
  stall_hold_a: assert property (!$past(ready_in, 2) && $past(reset_in_n, 2) |=>
    $stable(addr_out) && $stable(read_write_strobe) && $stable(opcode_fetch))
    else $error("bus moved in stall");
  vec_range_a: assert property (!vector_pull_n |-> addr_out >= 16'hfffa && read_write_strobe)
    else $error("vector address wrong");
  reset_vec_a: assert property ($fell(reset_active) |->
    $past(addr_out) == 16'hfffd && !$past(vector_pull_n)) else $error("reset vector wrong");
  reset_len_a: assert property ($rose(reset_in_n) |-> ##[8:11] $fell(reset_active))
    else $error("reset sequence length");
  fetch_mark_a: assert property (opcode_fetch |-> read_write_strobe && !reset_active)
    else $error("fetch marker wrong");
  reset_status_a: assert property (reset_active |-> status_out[2] && !status_out[3])
    else $error("reset status bits");
  wait_pull_a: assert property (wait_for_interrupt_instr && reset_in_n |=> ready_oe && !wait_n)
    else $error("wait not pulled");
  set_ovf_a: assert property ($fell(set_overflow_in_n) |-> ##[3:4] status_out[6])
    else $error("overflow not set");
endmodule
`default_nettype wire

//--- bench/cbag_mem.sv
// Purpose: Memory and ready pin on the far side of the bus
// Assumes: Reads answer within the cycle from the array
// Notes: An undriven bus returns a toggling byte, never a stale one
`timescale 1ns/1ps
`default_nettype none
module cbag_mem (
  input wire logic ref_clk,
  input wire logic [15:0] addr_out,
  input wire logic addr_oe,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic read_write_strobe,
  input wire logic stall_n,
  input wire logic ready_oe,
  output logic [7:0] data_in,
  output logic ready_in
);
  logic [7:0] mem [0:65535];
  logic [7:0] last = 8'h00;
  // Pulled-up pin: low when stepped or when the core waits
  assign ready_in = stall_n && !ready_oe;
  assign data_in = addr_oe ? mem[addr_out] : ~last;
  always @(posedge ref_clk) begin
    last <= data_in;
    if (addr_oe && data_oe && !read_write_strobe) begin
      mem[addr_out] <= data_out;
    end
  end
endmodule
`default_nettype wire

//--- bench/cbag_bus_ctrl_tb.sv
// Purpose: Self-checking bench of the bus control block
// Assumes: Operand bytes reach the block through fetch requests
// Notes: Memory contents are set directly in the model
`timescale 1ns/1ps
`default_nettype none
module cbag_bus_ctrl_tb;
  logic ref_clk = 1'b0, rst = 1'b1, reset_in_n = 1'b0, set_overflow_in_n = 1'b1;
  logic bus_drive_enable = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_use_x = 1'b0;
  logic req_cond_met = 1'b0, stall_n = 1'b1, wait_for_interrupt_instr = 1'b0, wake = 1'b0;
  logic status_wr = 1'b0;
  logic [3:0] req_op = 4'h0;
  logic [1:0] req_vec_sel = 2'h0;
  logic [7:0] req_wdata = 8'h00, index_x = 8'h90, index_y = 8'h0f;
  logic [7:0] stack_ptr = 8'hfd, status_wdata = 8'h00;
  logic [7:0] data_in, data_out, rdata, status_out;
  logic [15:0] addr_out, pc_out;
  logic ready_in, addr_oe, data_oe, read_write_strobe, rw_oe, ready_out, ready_oe, wait_n;
  logic opcode_fetch, vector_pull_n, busy, req_taken, done, reset_active;
  int failures = 0, n_compared = 0;
  int n_vpull = 0;
  cbag_bus_ctrl dut_u (.*);
  cbag_mem mem_u (.*);
  initial forever #2.5 ref_clk = ~ref_clk;
  // Vector-pull cycles, counted mid-cycle where the level is settled
  always @(negedge ref_clk) if (vector_pull_n === 1'b0) n_vpull++;
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic tmo(input logic ok);
    if (ok !== 1'b1) begin
      failures++;
      $display("[ERR] %0t wait ran out", $time);
      end_of_test();
    end
  endtask
  task automatic till_done;
    for (int i = 0; i < 60 && done !== 1'b1; i++) cyc(1);
    tmo(done);
  endtask
  task automatic req(input logic [3:0] op, input logic wr, input logic [7:0] wd);
    req_op = op;
    req_write = wr;
    req_wdata = wd;
    req_valid = 1'b1;
    for (int i = 0; i < 60 && req_taken !== 1'b1; i++) cyc(1);
    req_valid = 1'b0;
    till_done();
  endtask
  task automatic t_reset(input logic ov);
    reset_in_n = 1'b0;
    stall_n = 1'b0;
    cyc(4);
    stall_n = 1'b1;
    reset_in_n = 1'b1;
    for (int i = 0; i < 30 && busy !== 1'b0; i++) cyc(1);
    tmo(busy === 1'b0);
    chk(pc_out, 16'h1234);
    chk(16'(status_out[3:2]), 16'h1);
    chk(16'(status_out[6]), 16'(ov));
    $display("reset test done");
  endtask
  task automatic t_modes;
    logic [15:0] ea [5] = '{16'h2080, 16'h2110, 16'h208f, 16'h0080, 16'h01fd};
    req(4'h0, 1'b0, 8'h00);
    chk(16'(rdata), 16'h00ea);
    req(4'h1, 1'b0, 8'h00);
    req(4'h2, 1'b0, 8'h00);
    req(4'h3, 1'b0, 8'h00);
    chk(pc_out, 16'h1237);
    for (int i = 0; i < 5; i++) begin
      mem_u.mem[ea[i]] = 8'h40 + i[7:0];
      req(4'h4 + i[3:0], 1'b0, 8'h00);
      chk(16'(rdata), 16'h0040 + 16'(i));
      req(4'h4 + i[3:0], 1'b1, 8'hc0 + i[7:0]);
      chk(16'(mem_u.mem[ea[i]]), 16'h00c0 + 16'(i));
    end
    $display("address modes done");
  endtask
  task automatic t_flow;
    logic [15:0] vec [3] = '{16'haa11, 16'hbb22, 16'h1234};
    int vp0;
    req(4'h1, 1'b0, 8'h00);
    req_cond_met = 1'b1;
    req(4'ha, 1'b0, 8'h00);
    chk(pc_out, 16'h1228);
    req_cond_met = 1'b0;
    req(4'ha, 1'b0, 8'h00);
    chk(pc_out, 16'h1228);
    req(4'h1, 1'b0, 8'h00);
    req(4'h2, 1'b0, 8'h00);
    req_use_x = 1'b1;
    req(4'h9, 1'b0, 8'h00);
    chk(pc_out, 16'h5678);
    req_use_x = 1'b0;
    req(4'hc, 1'b0, 8'h00);
    chk(pc_out, 16'h3010);
    vp0 = n_vpull;
    for (int i = 0; i < 3; i++) begin
      req_vec_sel = i[1:0];
      req(4'hb, 1'b0, 8'h00);
      chk(pc_out, vec[i]);
    end
    chk(16'(n_vpull - vp0), 16'h6);
    $display("branch, jump and vector done");
  endtask
  task automatic t_stall;
    stall_n = 1'b0;
    cyc(1);
    req_op = 4'h0;
    req_valid = 1'b1;
    cyc(2);
    req_valid = 1'b0;
    bus_drive_enable = 1'b0;
    cyc(8);
    chk(16'(rw_oe), 16'h0);
    chk(16'(addr_oe), 16'h0);
    chk(16'(done), 16'h0);
    chk(addr_out, 16'h1234);
    chk(pc_out, 16'h1234);
    chk(16'(opcode_fetch), 16'h1);
    bus_drive_enable = 1'b1;
    stall_n = 1'b1;
    till_done();
    chk(16'(rdata), 16'h00ea);
    $display("stall test done");
  endtask
  task automatic t_wait;
    wait_for_interrupt_instr = 1'b1;
    cyc(1);
    wait_for_interrupt_instr = 1'b0;
    chk(16'({ready_oe, wait_n}), 16'h2);
    chk(16'(ready_out), 16'h0);
    cyc(3);
    req_op = 4'h0;
    req_valid = 1'b1;
    cyc(6);
    chk(16'(busy), 16'h0);
    chk(pc_out, 16'h1235);
    wake = 1'b1;
    cyc(1);
    wake = 1'b0;
    chk(16'({ready_oe, wait_n}), 16'h1);
    req(4'h0, 1'b0, 8'h00);
    chk(16'(rdata), 16'h0080);
    $display("wait test done");
  endtask
  task automatic t_ovf;
    status_wr = 1'b1;
    cyc(1);
    status_wr = 1'b0;
    cyc(1);
    chk(16'(status_out[6]), 16'h0);
    set_overflow_in_n = 1'b0;
    cyc(6);
    set_overflow_in_n = 1'b1;
    chk(16'(status_out[6]), 16'h1);
    t_reset(1'b1);
  endtask
  initial begin
    mem_u.mem[16'h1234] = 8'hea;
    mem_u.mem[16'h1235] = 8'h80;
    mem_u.mem[16'h1236] = 8'h20;
    mem_u.mem[16'h1237] = 8'hf0;
    mem_u.mem[16'h1228] = 8'h10;
    mem_u.mem[16'h1229] = 8'h30;
    mem_u.mem[16'h30a0] = 8'h78;
    mem_u.mem[16'h30a1] = 8'h56;
    mem_u.mem[16'hfffe] = 8'h11;
    mem_u.mem[16'hffff] = 8'haa;
    mem_u.mem[16'hfffa] = 8'h22;
    mem_u.mem[16'hfffb] = 8'hbb;
    mem_u.mem[16'hfffc] = 8'h34;
    mem_u.mem[16'hfffd] = 8'h12;
    cyc(4);
    rst = 1'b0;
    t_reset(1'b0);
    t_modes();
    t_flow();
    t_stall();
    t_wait();
    t_ovf();
    end_of_test();
  end
endmodule
bind cbag_bus_ctrl cbag_chk chk_u (.*);
`default_nettype wire
